// [common/dma_irq_pkg.sv]
package dma_irq_pkg;

  localparam int         DATA_W      = 32;
  localparam int         ADDR_W      = 32;
  localparam int         EP_COUNT    = 32;
  localparam int         SUMMARY_W   = 3;

  // =====================================================================
  // register byte addresses
  localparam logic [ADDR_W-1:0] DMA_IRQ_SUMMARY_ADDR    = 32'hE0090090;
  localparam logic [ADDR_W-1:0] DMA_IRQ_ENABLE_ADDR     = 32'hE0090094;
  localparam logic [ADDR_W-1:0] XFER_DONE_STATUS_ADDR   = 32'hE00900A0;
  localparam logic [ADDR_W-1:0] XFER_DONE_CLEAR_ADDR    = 32'hE00900A4;
  localparam logic [ADDR_W-1:0] XFER_DONE_SET_ADDR      = 32'hE00900A8;
  localparam logic [ADDR_W-1:0] DESC_REQ_STATUS_ADDR    = 32'hE00900AC;
  localparam logic [ADDR_W-1:0] DESC_REQ_CLEAR_ADDR     = 32'hE00900B0;
  localparam logic [ADDR_W-1:0] DESC_REQ_SET_ADDR       = 32'hE00900B4;
  localparam logic [ADDR_W-1:0] BUS_ERR_STATUS_ADDR     = 32'hE00900B8;
  localparam logic [ADDR_W-1:0] BUS_ERR_CLEAR_ADDR      = 32'hE00900BC;
  localparam logic [ADDR_W-1:0] BUS_ERR_SET_ADDR        = 32'hE00900C0;

  // =====================================================================
  // field positions in summary and enable
  localparam int         XFER_DONE_BIT = 0;
  localparam int         DESC_REQ_BIT  = 1;
  localparam int         BUS_ERR_BIT   = 2;

  localparam logic [SUMMARY_W-1:0] ENABLE_RESET = 3'h0;
  localparam logic [EP_COUNT-1:0]  STATUS_RESET = 32'h0;
  localparam logic [1:0]           RESP_OKAY    = 2'h0;
  localparam logic [1:0]           RESP_SLVERR  = 2'h2;

  // =====================================================================
  // per-endpoint event pulses from the dma engine
  typedef struct packed {
    logic [EP_COUNT-1:0] xfer_done;
    logic [EP_COUNT-1:0] descriptor_request;
    logic [EP_COUNT-1:0] bus_error;
  } ep_events_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_RESP = 2'h1
  } bus_state_t;

endpackage

// [src/usb_dma_irq_summary_enable.sv]
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module usb_dma_irq_summary_enable (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_b,
  // events from the dma engine, same clock
  input  wire dma_irq_pkg::ep_events_t      ep_events,
  // axi4-lite write address
  input  wire logic [dma_irq_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  // axi4-lite write data
  input  wire logic [dma_irq_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  // axi4-lite read address
  input  wire logic [dma_irq_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  // axi4-lite read data
  output logic [dma_irq_pkg::DATA_W-1:0]    s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // interrupt and observed state
  output logic                              dma_irq,
  output logic [dma_irq_pkg::SUMMARY_W-1:0] dma_irq_summary
);
  import dma_irq_pkg::*;

  // ===================================================================
  // reset synchroniser
  logic rst_meta_b;
  logic rst_sync_b;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ===================================================================
  // write channel: address and data caught in either order
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic              wr_addr_held;
  logic              wr_data_held;
  logic              wr_fire;
  logic              wr_hit;

  assign s_axi_awready = !wr_addr_held && !s_axi_bvalid;
  assign s_axi_wready  = !wr_data_held && !s_axi_bvalid;
  assign wr_fire       = wr_addr_held && wr_data_held;

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wr_addr_held <= 1'b0;
      wr_addr      <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      wr_addr_held <= 1'b1;
      wr_addr      <= s_axi_awaddr;
    end else if (wr_fire) begin
      wr_addr_held <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wr_data_held <= 1'b0;
      wr_data      <= '0;
      wr_strb      <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wr_data_held <= 1'b1;
      wr_data      <= s_axi_wdata;
      wr_strb      <= s_axi_wstrb;
    end else if (wr_fire) begin
      wr_data_held <= 1'b0;
    end
  end

  always_comb begin
    case (wr_addr)
      DMA_IRQ_ENABLE_ADDR,
      XFER_DONE_CLEAR_ADDR, XFER_DONE_SET_ADDR,
      DESC_REQ_CLEAR_ADDR,  DESC_REQ_SET_ADDR,
      BUS_ERR_CLEAR_ADDR,   BUS_ERR_SET_ADDR: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // byte-lane mask of the write data
  logic [DATA_W-1:0] wr_mask;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_mask[i*8 +: 8] = {8{wr_strb[i]}};
    end
  end

  function automatic logic wr_at(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] target,
                                 input logic              fire);
    wr_at = fire && (a == target);
  endfunction

  // ===================================================================
  // enable register
  logic [SUMMARY_W-1:0] dma_irq_enable;

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      dma_irq_enable <= ENABLE_RESET;
    end else if (wr_at(wr_addr, DMA_IRQ_ENABLE_ADDR, wr_fire)) begin
      dma_irq_enable <= (wr_data[SUMMARY_W-1:0] & wr_mask[SUMMARY_W-1:0])
                      | (dma_irq_enable & ~wr_mask[SUMMARY_W-1:0]);
    end
  end

  // ===================================================================
  // per-endpoint status; a hardware set wins over a software clear
  logic [EP_COUNT-1:0] endpoint_xfer_done_status;
  logic [EP_COUNT-1:0] endpoint_descriptor_request_status;
  logic [EP_COUNT-1:0] endpoint_bus_error_status;

  function automatic logic [EP_COUNT-1:0] next_status(
      input logic [EP_COUNT-1:0] cur,
      input logic [EP_COUNT-1:0] hw_set,
      input logic                sw_set,
      input logic                sw_clr,
      input logic [EP_COUNT-1:0] bits);
    logic [EP_COUNT-1:0] clr;
    logic [EP_COUNT-1:0] set;
    clr = sw_clr ? bits : STATUS_RESET;
    set = sw_set ? bits : STATUS_RESET;
    next_status = (cur & ~clr) | set | hw_set;
  endfunction

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      endpoint_xfer_done_status <= STATUS_RESET;
    end else begin
      endpoint_xfer_done_status <= next_status(endpoint_xfer_done_status,
        ep_events.xfer_done,
        wr_at(wr_addr, XFER_DONE_SET_ADDR, wr_fire),
        wr_at(wr_addr, XFER_DONE_CLEAR_ADDR, wr_fire),
        wr_data & wr_mask);
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      endpoint_descriptor_request_status <= STATUS_RESET;
    end else begin
      endpoint_descriptor_request_status <= next_status(
        endpoint_descriptor_request_status,
        ep_events.descriptor_request,
        wr_at(wr_addr, DESC_REQ_SET_ADDR, wr_fire),
        wr_at(wr_addr, DESC_REQ_CLEAR_ADDR, wr_fire),
        wr_data & wr_mask);
    end
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      endpoint_bus_error_status <= STATUS_RESET;
    end else begin
      endpoint_bus_error_status <= next_status(endpoint_bus_error_status,
        ep_events.bus_error,
        wr_at(wr_addr, BUS_ERR_SET_ADDR, wr_fire),
        wr_at(wr_addr, BUS_ERR_CLEAR_ADDR, wr_fire),
        wr_data & wr_mask);
    end
  end

  // ===================================================================
  // summary and interrupt
  logic xfer_done_summary;
  logic descriptor_request_summary;
  logic bus_error_summary;

  assign xfer_done_summary          = |endpoint_xfer_done_status;
  assign descriptor_request_summary = |endpoint_descriptor_request_status;
  assign bus_error_summary          = |endpoint_bus_error_status;

  always_comb begin
    dma_irq_summary                = '0;
    dma_irq_summary[XFER_DONE_BIT] = xfer_done_summary;
    dma_irq_summary[DESC_REQ_BIT]  = descriptor_request_summary;
    dma_irq_summary[BUS_ERR_BIT]   = bus_error_summary;
  end

  assign dma_irq = |(dma_irq_summary & dma_irq_enable);

  // ===================================================================
  // read channel: one read at a time, data registered
  logic [DATA_W-1:0] rd_word;
  logic              rd_hit;

  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      DMA_IRQ_SUMMARY_ADDR:  rd_word[SUMMARY_W-1:0] = dma_irq_summary;
      DMA_IRQ_ENABLE_ADDR:   rd_word[SUMMARY_W-1:0] = dma_irq_enable;
      XFER_DONE_STATUS_ADDR: rd_word = endpoint_xfer_done_status;
      DESC_REQ_STATUS_ADDR:  rd_word = endpoint_descriptor_request_status;
      BUS_ERR_STATUS_ADDR:   rd_word = endpoint_bus_error_status;
      default:               rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [tb/usb_dma_irq_summary_enable_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module usb_dma_irq_summary_enable_chk (
  // observed ports
  input wire logic                    core_clk,
  input wire logic                    rst_b,
  input wire dma_irq_pkg::ep_events_t ep_events,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic                    dma_irq,
  input wire logic [2:0]              dma_irq_summary
);
  import dma_irq_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_done_summary: assert property (|ep_events.xfer_done |=>
    dma_irq_summary[0]) else $error("done summary missed");
  a_request_summary: assert property (|ep_events.descriptor_request
    |=> dma_irq_summary[1]) else $error("request summary missed");
  a_error_summary: assert property (|ep_events.bus_error |=>
    dma_irq_summary[2]) else $error("error summary missed");
  a_irq_gated: assert property (dma_irq |->
    |dma_irq_summary) else $error("irq without summary");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_b |->
    !dma_irq && dma_irq_summary == 3'h0) else $error("not quiet in reset");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write not answered");
  c_irq: cover property (dma_irq);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_read: cover property (s_axi_arvalid && s_axi_arready);
endmodule
bind usb_dma_irq_summary_enable usb_dma_irq_summary_enable_chk
  usb_dma_irq_summary_enable_chk_i (.core_clk, .rst_b, .ep_events,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .dma_irq, .dma_irq_summary);
`default_nettype wire

// [tb/test_usb_dma_irq_summary_enable.sv]
`timescale 1ns/1ns
`default_nettype none
module test_usb_dma_irq_summary_enable;
  import dma_irq_pkg::*;
  logic        core_clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, dma_irq;
  logic [31:0] awaddr, wdata, araddr, rdata, rd_val;
  logic [1:0]  bresp, rresp, rsp;
  logic [2:0]  summary;
  ep_events_t  ep_events;
  int          n_errors, n_compared;
  logic [31:0] clr [3] = '{XFER_DONE_CLEAR_ADDR, DESC_REQ_CLEAR_ADDR,
                           BUS_ERR_CLEAR_ADDR};
  usb_dma_irq_summary_enable usb_dma_irq_summary_enable_i (
    .core_clk, .rst_b, .ep_events, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .dma_irq, .dma_irq_summary(summary));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // ==========================================================
  // bus tasks: handshakes judged at negedge, where all is settled
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge core_clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid;
      rsp = bresp;
      @(posedge core_clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (!b_t);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    logic ar_t, r_t;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge core_clk);
      ar_t = arvalid && arready;
      r_t = rvalid;
      rd_val = rdata;
      rsp = rresp;
      @(posedge core_clk);
      if (ar_t) arvalid <= 1'b0;
    end while (!r_t);
    rready <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(DMA_IRQ_SUMMARY_ADDR);
    chk(rd_val, 32'h0);
    rd(DMA_IRQ_ENABLE_ADDR);
    chk(rd_val, 32'h0);
    chk({31'h0, dma_irq}, 32'h0);
  endtask
  task automatic t_sources;
    logic [31:0] one;
    for (int i = 0; i < 3; i++) begin
      one = 32'h1 << i;
      wr(DMA_IRQ_ENABLE_ADDR, 32'h7 ^ one);
      // two endpoints at once, bits 31 and 0 of the same source
      @(posedge core_clk);
      ep_events <= (96'h1 << (95 - 32 * i)) | (96'h1 << (64 - 32 * i));
      @(posedge core_clk);
      ep_events <= '0;
      @(negedge core_clk);
      chk({29'h0, summary}, one);
      chk({31'h0, dma_irq}, 32'h0);
      wr(DMA_IRQ_ENABLE_ADDR, one);
      rd(DMA_IRQ_ENABLE_ADDR);
      chk(rd_val, one);
      chk({31'h0, dma_irq}, 32'h1);
      wr(clr[i], 32'h80000000);
      rd(DMA_IRQ_SUMMARY_ADDR);
      chk(rd_val, one);
      wr(clr[i], 32'h1);
      @(negedge core_clk);
      chk({29'h0, summary}, 32'h0);
      chk({31'h0, dma_irq}, 32'h0);
    end
  endtask
  task automatic t_unmapped;
    wr(32'hE0090098, 32'h1);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(DMA_IRQ_SUMMARY_ADDR, 32'h7);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    rd(32'hE0090098);
    chk(rd_val, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    rd(DMA_IRQ_ENABLE_ADDR);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask
  task automatic test_done;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    test_done;
  end
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    ep_events = '0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset;
    t_sources;
    t_unmapped;
    test_done;
  end
endmodule
`default_nettype wire
